// [common/drb_pkg.sv]
// constants for the extended diagnostic record builder
package drb_pkg;
	// ---------------------------------------------------------------
	// record layout
	// ---------------------------------------------------------------
	localparam int REC_BYTES = 16;
	localparam int BASIC_BYTES = 4;
	localparam logic [3:0] IDX_CHAN_TYPE = 4'h4;
	localparam logic [3:0] IDX_DIAG_BITS = 4'h5;
	localparam logic [3:0] IDX_CHAN_COUNT = 4'h6;
	localparam logic [3:0] IDX_GROUP_ERR = 4'h7;
	localparam logic [3:0] IDX_LOST_LOW = 4'h8;
	localparam logic [3:0] IDX_LOST_HIGH = 4'h9;
	localparam logic [3:0] IDX_LOST_UPPER = 4'ha;
	localparam logic [3:0] IDX_RSVD_11 = 4'hb;
	localparam logic [3:0] IDX_LOST_MEAS0 = 4'hc;
	localparam logic [3:0] IDX_LOST_MEAS1 = 4'hd;
	localparam logic [3:0] IDX_RSVD_14 = 4'he;
	localparam logic [3:0] IDX_RSVD_15 = 4'hf;
	localparam logic [6:0] CHAN_TYPE_DIG_IN = 7'h70;
	localparam logic [7:0] DIAG_BITS_VAL = 8'h08;
	localparam logic [7:0] CHAN_COUNT_VAL = 8'h08;
	localparam logic [7:0] BASIC_BYTE1_VAL = 8'h1f;
	// byte 0 and byte 3 bit positions
	localparam int B0_MOD_FAIL = 0;
	localparam int B0_EXT_ERR = 2;
	localparam int B0_CHAN_ERR = 3;
	localparam int B3_LOST = 6;
	// byte 7 bit positions of the meter errors
	localparam int B7_METER0 = 4;
	localparam int B7_METER1 = 5;
	// ---------------------------------------------------------------
	// own registers (byte addresses)
	// ---------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL = 8'h40;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h44;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h48;
	localparam logic [7:0] ADDR_LOST_CLR = 8'h4c;
	localparam int CTRL_MODE_PWM = 0;
	localparam int CTRL_MORE_TYPES = 1;
	localparam int CTRL_RELEASE_EN = 2;
	localparam logic [2:0] CTRL_RESET = 3'h4;
	localparam int IRQ_INCOMING = 0;
	localparam int IRQ_OUTGOING = 1;
	localparam int IRQ_LOST = 2;
	localparam logic [2:0] IRQ_MASK_RESET = 3'h0;
	localparam int LOST_INPUTS = 10;
	localparam int LOST_MEAS = 2;
	typedef enum logic [1:0] {
		DRB_IDLE = 2'b00,
		DRB_WAIT = 2'b01,
		DRB_DONE = 2'b10
	} drb_apb_e;
endpackage

// [hdl/drb_top.sv]
// extended diagnostic record builder with apb register access
// Behaviour
// RULE_01 - The record is four basic bytes followed by twelve module bytes, sixteen in all.
// RULE_02 - Byte 4 bits 6..0 carry the channel type code, here digital input 70h.
// RULE_03 - Byte 4 bit 7 tells whether further channel types are present.
// RULE_04 - Byte 5 gives eight diagnostic bits per channel.
// RULE_05 - Byte 6 gives eight channels for the module.
// RULE_06 - Byte 7 bits 0, 1 and 2 flag errors of the three input channel groups.
// RULE_07 - In frequency mode byte 7 bits 4 and 5 flag meter 0 and meter 1 errors.
// RULE_08 - In pulse width mode byte 7 holds only the three group error bits.
// RULE_09 - Byte 8 even bits flag lost process interrupts of inputs 0.0 to 0.3, odd bits zero.
// RULE_10 - Byte 9 even bits flag lost process interrupts of inputs 0.4 to 0.7, odd bits zero.
// RULE_11 - Byte 10 bits 0 and 2 flag lost interrupts of inputs 1.0 and 1.1, the rest zero.
// RULE_12 - In frequency mode byte 12 bit 0 flags a lost end of integration on channel 0.
// RULE_13 - In frequency mode byte 13 bit 0 flags a lost end of integration on channel 1.
// RULE_14 - Byte 11 is always reserved, bytes 12 to 15 reserved as each mode says.
// RULE_15 - Basic byte 0 shows module failure, external error and channel error at bits 0, 2, 3.
// RULE_16 - An outgoing message on error removal is sent only while release is enabled.
// RULE_17 - Reserved bits read zero and reading never changes a flag.
`timescale 1ns/100ps
module drb_top
	import drb_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pce,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// error sources from the i/o side
	input wire logic module_fail_in,
	input wire logic ext_error_in,
	input wire logic [2:0] group_error_in,
	input wire logic [1:0] meter_error_in,
	input wire logic [drb_pkg::LOST_INPUTS-1:0] lost_input_in,
	input wire logic [drb_pkg::LOST_MEAS-1:0] lost_meas_in,
	// events and interrupt
	output logic diag_outgoing,
	output logic irq
);
	import drb_pkg::*;

	// ---------------------------------------------------------------
	// input synchronisers
	// ---------------------------------------------------------------
	localparam int SYNC_W = 2 + 3 + 2 + LOST_INPUTS + LOST_MEAS;
	logic [SYNC_W-1:0] sync1_reg;
	logic [SYNC_W-1:0] sync2_reg;
	logic [LOST_INPUTS+LOST_MEAS-1:0] lost_prev_reg;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sync1_reg <= '0;
			sync2_reg <= '0;
		end
		else if (pce)
		begin
			sync1_reg <= {module_fail_in, ext_error_in, group_error_in, meter_error_in,
				lost_input_in, lost_meas_in};
			sync2_reg <= sync1_reg;
		end
	end

	logic mod_fail_s;
	logic ext_err_s;
	logic [2:0] group_err_s;
	logic [1:0] meter_err_s;
	logic [LOST_INPUTS+LOST_MEAS-1:0] lost_s;
	assign {mod_fail_s, ext_err_s, group_err_s, meter_err_s, lost_s} = sync2_reg;

	// ---------------------------------------------------------------
	// control register
	// ---------------------------------------------------------------
	logic [2:0] ctrl_reg;
	logic [2:0] irq_mask_reg;
	logic [2:0] irq_stat_reg;
	logic [LOST_INPUTS+LOST_MEAS-1:0] lost_reg;
	drb_apb_e state_reg;
	logic wr_take;
	logic rd_take;
	logic addr_ok;

	// the write lands on the edge where pready is seen high
	assign wr_take = psel && penable && pwrite && pready && (state_reg == DRB_DONE);
	assign rd_take = psel && penable && !pwrite && (state_reg == DRB_WAIT);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ctrl_reg <= CTRL_RESET;
		else if (pce && wr_take && paddr == ADDR_CTRL)
			ctrl_reg <= pwdata[2:0];
	end

	logic pwm_mode;
	assign pwm_mode = ctrl_reg[CTRL_MODE_PWM];

	// ---------------------------------------------------------------
	// lost process interrupt flags
	// ---------------------------------------------------------------
	logic [LOST_INPUTS+LOST_MEAS-1:0] lost_rise;
	logic [LOST_INPUTS+LOST_MEAS-1:0] lost_clr;
	assign lost_rise = lost_s & ~lost_prev_reg;
	assign lost_clr = (wr_take && paddr == ADDR_LOST_CLR) ?
		pwdata[LOST_INPUTS+LOST_MEAS-1:0] : '0;

	// a new loss in the clear cycle survives the clear
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			lost_prev_reg <= '0;
			lost_reg <= '0;
		end
		else if (pce)
		begin
			lost_prev_reg <= lost_s;
			lost_reg <= (lost_reg & ~lost_clr) | lost_rise; // [RULE_17]
		end
	end

	// ---------------------------------------------------------------
	// record assembly
	// ---------------------------------------------------------------
	logic chan_err;
	assign chan_err = (|group_err_s) || (!pwm_mode && (|meter_err_s));

	// lost flags sit on even bit positions, odd positions stay zero
	function automatic logic [7:0] spread4(input logic [3:0] f);
		spread4 = {1'b0, f[3], 1'b0, f[2], 1'b0, f[1], 1'b0, f[0]};
	endfunction

	function automatic logic [7:0] rec_byte(input logic [3:0] idx);
		logic [7:0] b;
		b = 8'h00;
		case (idx)
			4'h0:
			begin
				b[B0_MOD_FAIL] = mod_fail_s; // [RULE_15]
				b[B0_EXT_ERR] = ext_err_s; // [RULE_15]
				b[B0_CHAN_ERR] = chan_err; // [RULE_15]
			end
			4'h1: b = BASIC_BYTE1_VAL;
			4'h3: b[B3_LOST] = |lost_reg;
			IDX_CHAN_TYPE: b = {ctrl_reg[CTRL_MORE_TYPES], CHAN_TYPE_DIG_IN}; // [RULE_02] [RULE_03]
			IDX_DIAG_BITS: b = DIAG_BITS_VAL; // [RULE_04]
			IDX_CHAN_COUNT: b = CHAN_COUNT_VAL; // [RULE_05]
			IDX_GROUP_ERR:
			begin
				b[2:0] = group_err_s; // [RULE_06]
				if (!pwm_mode) // [RULE_08]
				begin
					b[B7_METER0] = meter_err_s[0]; // [RULE_07]
					b[B7_METER1] = meter_err_s[1]; // [RULE_07]
				end
			end
			IDX_LOST_LOW: b = spread4(lost_reg[LOST_MEAS+3:LOST_MEAS]); // [RULE_09]
			IDX_LOST_HIGH: b = spread4(lost_reg[LOST_MEAS+7:LOST_MEAS+4]); // [RULE_10]
			IDX_LOST_UPPER: b = spread4({2'b00, lost_reg[LOST_MEAS+9:LOST_MEAS+8]}); // [RULE_11]
			IDX_LOST_MEAS0: b[0] = !pwm_mode && lost_reg[0]; // [RULE_12] [RULE_14]
			IDX_LOST_MEAS1: b[0] = !pwm_mode && lost_reg[1]; // [RULE_13] [RULE_14]
			default: b = 8'h00; // [RULE_14] [RULE_17]
		endcase
		rec_byte = b;
	endfunction

	// flat view of the record so that assertions see sampled values, not live ones
	logic [7:0] rec_view [REC_BYTES];
	always_comb
	begin
		for (int i = 0; i < REC_BYTES; i++)
			rec_view[i] = rec_byte(4'(i));
	end

	// ---------------------------------------------------------------
	// diagnostic events and interrupt
	// ---------------------------------------------------------------
	logic err_any;
	logic err_prev_reg;
	logic err_came;
	logic err_gone;
	logic [2:0] irq_set;
	logic [2:0] irq_clr;
	assign err_any = mod_fail_s || ext_err_s || chan_err;
	assign err_came = err_any && !err_prev_reg;
	assign err_gone = !err_any && err_prev_reg;
	assign irq_set = {|lost_rise, err_gone && ctrl_reg[CTRL_RELEASE_EN], err_came};
	assign irq_clr = (wr_take && paddr == ADDR_IRQ_STAT) ? pwdata[2:0] : 3'h0;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			err_prev_reg <= 1'b0;
			diag_outgoing <= 1'b0;
		end
		else if (pce)
		begin
			err_prev_reg <= err_any;
			diag_outgoing <= err_gone && ctrl_reg[CTRL_RELEASE_EN]; // [RULE_16]
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq_mask_reg <= IRQ_MASK_RESET;
		else if (pce && wr_take && paddr == ADDR_IRQ_MASK)
			irq_mask_reg <= pwdata[2:0];
	end

	// set wins over a write-one-to-clear in the same cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq_stat_reg <= 3'h0;
		else if (pce)
			irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq <= 1'b0;
		else if (pce)
			irq <= |(((irq_stat_reg & ~irq_clr) | irq_set) & irq_mask_reg);
	end

	// ---------------------------------------------------------------
	// apb slave: one wait state, pready is a flop
	// ---------------------------------------------------------------
	// record bytes sit one per word, byte n at address 4n
	assign addr_ok = (paddr[1:0] == 2'b00) && ((paddr[7:6] == 2'b00) ||
		paddr == ADDR_CTRL || paddr == ADDR_IRQ_STAT ||
		paddr == ADDR_IRQ_MASK || paddr == ADDR_LOST_CLR); // [RULE_01]

	function automatic logic [31:0] read_word(input logic [7:0] a);
		logic [31:0] w;
		w = 32'h0000_0000;
		if (a[7:6] == 2'b00)
			w = {24'h00_0000, rec_byte(a[5:2])};
		else if (a == ADDR_CTRL)
			w = {29'h0, ctrl_reg};
		else if (a == ADDR_IRQ_STAT)
			w = {29'h0, irq_stat_reg};
		else if (a == ADDR_IRQ_MASK)
			w = {29'h0, irq_mask_reg};
		else
			w = 32'h0000_0000;
		read_word = w;
	endfunction

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_reg <= DRB_IDLE;
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end
		else if (pce)
		begin
			case (state_reg)
				DRB_IDLE:
				begin
					pready <= 1'b0;
					pslverr <= 1'b0;
					if (psel && !penable)
						state_reg <= DRB_WAIT;
				end
				DRB_WAIT:
				begin
					if (psel && penable)
					begin
						pready <= 1'b1;
						pslverr <= !addr_ok;
						// read is side-effect free
						prdata <= rd_take ? read_word(paddr) : 32'h0000_0000; // [RULE_17]
						state_reg <= DRB_DONE;
					end
					else if (!psel)
						state_reg <= DRB_IDLE;
				end
				DRB_DONE:
				begin
					pready <= 1'b0;
					pslverr <= 1'b0;
					prdata <= 32'h0000_0000;
					state_reg <= (psel && !penable) ? DRB_WAIT : DRB_IDLE;
				end
				default:
				begin
					pready <= 1'b0;
					pslverr <= 1'b0;
					state_reg <= DRB_IDLE;
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	AST_CHAN_TYPE: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_02]
		rec_view[IDX_CHAN_TYPE] == {ctrl_reg[CTRL_MORE_TYPES], 7'h70})
		else $error("channel type byte wrong");
	AST_MORE_TYPES: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_03]
		pce && wr_take && paddr == ADDR_CTRL |=>
		rec_view[IDX_CHAN_TYPE][7] == $past(pwdata[CTRL_MORE_TYPES]))
		else $error("more types flag not taken");
	AST_FIXED_COUNTS: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_04] [RULE_05]
		rec_view[IDX_DIAG_BITS] == 8'h08 && rec_view[IDX_CHAN_COUNT] == 8'h08)
		else $error("fixed count bytes wrong");
	AST_GROUP_ERR: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_06]
		rec_view[IDX_GROUP_ERR][3:0] == {1'b0, group_err_s})
		else $error("group error bits wrong");
	AST_METER_FREQ: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_07]
		!pwm_mode |-> rec_view[IDX_GROUP_ERR][7:4] == {2'b00, meter_err_s})
		else $error("meter error bits wrong");
	AST_METER_PWM: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_08]
		pwm_mode |-> rec_view[IDX_GROUP_ERR][7:3] == 5'h00)
		else $error("pwm byte 7 upper bits not zero");
	AST_LOST_STICKY: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_09]
		pce && (lost_rise[LOST_MEAS] || (lost_reg[LOST_MEAS] && !lost_clr[LOST_MEAS]))
		|=> rec_view[IDX_LOST_LOW][0])
		else $error("lost flag of input 0.0 not held");
	AST_ODD_ZERO: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_10]
		((rec_view[IDX_LOST_HIGH] | rec_view[IDX_LOST_LOW]) & 8'haa) == 8'h00)
		else $error("odd lost bit not zero");
	AST_UPPER: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_11]
		rec_view[IDX_LOST_UPPER][7:3] == 5'h00 && rec_view[IDX_LOST_UPPER][1] == 1'b0)
		else $error("byte 10 reserved bits not zero");
	AST_MEAS: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_12]
		rec_view[IDX_LOST_MEAS0] == {7'h00, !pwm_mode && lost_reg[0]} &&
		rec_view[IDX_LOST_MEAS1] == {7'h00, !pwm_mode && lost_reg[1]}) // [RULE_13]
		else $error("measurement lost byte wrong");
	AST_RSVD: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_14]
		rec_view[IDX_RSVD_11] == 8'h00 && rec_view[IDX_RSVD_14] == 8'h00 &&
		rec_view[IDX_RSVD_15] == 8'h00)
		else $error("reserved byte not zero");
	AST_BYTE0: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_15]
		rec_view[0] == {4'h0, chan_err, ext_err_s, 1'b0, mod_fail_s})
		else $error("basic byte 0 wrong");
	AST_OUTGOING: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_16]
		pce && err_gone |=> diag_outgoing == $past(ctrl_reg[CTRL_RELEASE_EN]))
		else $error("outgoing message does not follow release enable");
	AST_READ_CLEAN: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_17]
		pce && rd_take && lost_rise == '0 |=> lost_reg == $past(lost_reg))
		else $error("read changed a lost flag");
	AST_APB_ANSWER: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_01]
		pce && psel && !penable && state_reg == DRB_IDLE ##1 pce && psel && penable |=> pready)
		else $error("apb answer late");
	COV_READ: cover property (@(posedge pclk) disable iff (!presetn) rd_take ##1 pready);
	COV_WRITE: cover property (@(posedge pclk) disable iff (!presetn) wr_take);
	COV_OUTGOING: cover property (@(posedge pclk) disable iff (!presetn) diag_outgoing);
	COV_IRQ: cover property (@(posedge pclk) disable iff (!presetn) irq && pwm_mode);
endmodule

// [testbench/tb_diag_record_builder.sv]
// self-checking bench for the diagnostic record builder, apb reads against a bench model
`timescale 1ns/100ps
module tb_diag_record_builder;
	import drb_pkg::*;
	// ---------------------------------------------------------------
	// signals and model state
	// ---------------------------------------------------------------
	logic pclk = 1'b0;
	logic presetn, pce, psel, penable, pwrite;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, r, v;
	logic pready, pslverr, e, module_fail_in, ext_error_in, diag_outgoing, irq;
	logic [2:0] group_error_in;
	logic [1:0] meter_error_in, m_lm;
	logic [LOST_INPUTS-1:0] lost_input_in, m_lin;
	logic [LOST_MEAS-1:0] lost_meas_in;
	logic m_pwm, m_more;
	int miscompares, samples_checked, cycles, out_cnt, seed;

	drb_top u_dut (.pclk(pclk), .presetn(presetn), .pce(pce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.module_fail_in(module_fail_in), .ext_error_in(ext_error_in),
		.group_error_in(group_error_in), .meter_error_in(meter_error_in),
		.lost_input_in(lost_input_in), .lost_meas_in(lost_meas_in),
		.diag_outgoing(diag_outgoing), .irq(irq));

	always #20 pclk = ~pclk;

	// hang guard: the whole sequence needs under two thousand cycles
	always @(posedge pclk)
	begin
		cycles++;
		if (diag_outgoing === 1'b1)
			out_cnt++;
		if (cycles == 20000)
		begin
			miscompares++;
			tally_and_finish();
		end
	end

	// ---------------------------------------------------------------
	// model and tasks
	// ---------------------------------------------------------------
	function automatic logic [7:0] spread(input logic [3:0] x);
		return {1'b0, x[3], 1'b0, x[2], 1'b0, x[1], 1'b0, x[0]};
	endfunction

	function automatic logic [7:0] exp_rec(input int n);
		logic ce;
		ce = (|group_error_in) | (!m_pwm & (|meter_error_in));
		case (n)
			0: return {4'h0, ce, ext_error_in, 1'b0, module_fail_in};
			1: return 8'h1f;
			3: return {1'b0, |{m_lin, m_lm}, 6'h00};
			4: return {m_more, 7'h70};
			5, 6: return 8'h08;
			7: return {2'b00, m_pwm ? 2'b00 : meter_error_in, 1'b0, group_error_in};
			8: return spread(m_lin[3:0]);
			9: return spread(m_lin[7:4]);
			10: return {5'h00, m_lin[9], 1'b0, m_lin[8]};
			12: return {7'h00, !m_pwm & m_lm[0]};
			13: return {7'h00, !m_pwm & m_lm[1]};
			default: return 8'h00;
		endcase
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask

	// one apb transfer, entered right after a rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
		end
		while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// one idle edge, so a following setup never drives psel twice in one step
		@(posedge pclk);
	endtask

	task automatic check_record();
		logic [31:0] x;
		for (int n = 0; n < REC_BYTES; n++)
		begin
			apb(1'b0, 8'(n * 4), 32'h0);
			x = {24'h0, exp_rec(n)};
			if (n < 7)
				chk(r, x);
			else if (n < 11)
				chk(r, x);
			else
				chk(r, x);
			chk(e, 0);
		end
	endtask

	task automatic tally_and_finish();
		if (miscompares == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial
	begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{module_fail_in, ext_error_in, group_error_in, meter_error_in} = '0;
		{lost_input_in, lost_meas_in, m_lin, m_lm, m_pwm, m_more} = '0;
		pce = 1'b1;
		seed = 66807;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		cyc(1);
		apb(1'b0, ADDR_CTRL, 32'h0);
		chk(r, {29'h0, CTRL_RESET});
		apb(1'b0, ADDR_IRQ_MASK, 32'h0);
		chk(r, {29'h0, IRQ_MASK_RESET});
		check_record();
		// random error levels in both modes
		repeat (12)
		begin
			v = $random(seed);
			{module_fail_in, ext_error_in, group_error_in, meter_error_in} <= v[6:0];
			m_pwm = v[8];
			m_more = v[9];
			apb(1'b1, ADDR_CTRL, {29'h0, 1'b1, m_more, m_pwm});
			cyc(4);
			check_record();
		end
		// lost interrupts in frequency mode, read twice to see reads leave flags alone
		m_pwm = 1'b0;
		m_more = 1'b0;
		apb(1'b1, ADDR_CTRL, {29'h0, CTRL_RESET});
		repeat (4)
		begin
			v = $random(seed);
			lost_input_in <= v[9:0];
			lost_meas_in <= v[11:10];
			m_lin = m_lin | v[9:0];
			m_lm = m_lm | v[11:10];
			cyc(4);
			lost_input_in <= '0;
			lost_meas_in <= '0;
			cyc(4);
			check_record();
			check_record();
		end
		apb(1'b0, ADDR_IRQ_STAT, 32'h0);
		chk(r[IRQ_LOST], |{m_lin, m_lm});
		v = $random(seed);
		apb(1'b1, ADDR_LOST_CLR, {20'h0, v[11:0]});
		m_lm = m_lm & ~v[1:0];
		m_lin = m_lin & ~v[11:2];
		cyc(1);
		check_record();
		apb(1'b1, ADDR_LOST_CLR, 32'hfff);
		m_lin = '0;
		m_lm = '0;
		// pulse width mode hides the measurement flags
		apb(1'b1, ADDR_CTRL, 32'h5);
		lost_meas_in <= 2'b11;
		cyc(4);
		lost_meas_in <= 2'b00;
		cyc(4);
		apb(1'b0, {IDX_LOST_MEAS0, 2'b00}, 32'h0);
		chk(r, 0);
		apb(1'b0, {IDX_LOST_MEAS1, 2'b00}, 32'h0);
		chk(r, 0);
		apb(1'b1, ADDR_LOST_CLR, 32'hfff);
		// ignored record write and refused accesses
		apb(1'b1, 8'h10, 32'hff);
		chk(e, 0);
		m_pwm = 1'b1;
		apb(1'b0, 8'h10, 32'h0);
		chk(r, {24'h0, exp_rec(4)});
		apb(1'b0, 8'h50, 32'h0);
		chk({r[30:0], e}, 1);
		apb(1'b1, 8'h41, 32'h0);
		chk(e, 1);
		// interrupts and the outgoing event
		{module_fail_in, ext_error_in, group_error_in, meter_error_in} <= '0;
		apb(1'b1, ADDR_CTRL, {29'h0, CTRL_RESET});
		cyc(6);
		apb(1'b1, ADDR_IRQ_STAT, 32'h7);
		apb(1'b1, ADDR_IRQ_MASK, 32'h7);
		out_cnt = 0;
		group_error_in <= 3'h2;
		cyc(5);
		apb(1'b0, ADDR_IRQ_STAT, 32'h0);
		chk(r, 32'h1);
		chk(irq, 1);
		apb(1'b1, ADDR_IRQ_STAT, 32'h1);
		cyc(2);
		chk(irq, 0);
		group_error_in <= 3'h0;
		cyc(6);
		chk(out_cnt, 1);
		apb(1'b0, ADDR_IRQ_STAT, 32'h0);
		chk(r, 32'h2);
		chk(irq, 1);
		apb(1'b1, ADDR_IRQ_STAT, 32'h7);
		apb(1'b1, ADDR_IRQ_MASK, 32'h0);
		apb(1'b1, ADDR_CTRL, 32'h0);
		ext_error_in <= 1'b1;
		cyc(5);
		ext_error_in <= 1'b0;
		cyc(6);
		chk(out_cnt, 1);
		apb(1'b0, ADDR_IRQ_STAT, 32'h0);
		chk(r, 32'h1);
		chk(irq, 0);
		// clock enable low: a group error must not reach the record while frozen
		m_pwm = 1'b0;
		pce <= 1'b0;
		group_error_in <= 3'h1;
		cyc(6);
		pce <= 1'b1;
		apb(1'b0, {IDX_GROUP_ERR, 2'b00}, 32'h0);
		chk(r, 32'h0);
		check_record();
		tally_and_finish();
	end
endmodule
